//--- inc/fdcl_consts.svh
// Offsets, field positions, reset values and counts for the fuse config loader
// Assumes 8-bit register space addressed by a page select plus offset
`ifndef FDCL_CONSTS_SVH
`define FDCL_CONSTS_SVH
`define FDCL_OFF_LDO3_CFG     8'hD6
`define FDCL_OFF_VSNVS_CFG    8'hDA
`define FDCL_OFF_OVBYP1       8'hDB
`define FDCL_OFF_OVBYP2       8'hDC
`define FDCL_OFF_UVBYP1       8'hDD
`define FDCL_OFF_UVBYP2       8'hDE
`define FDCL_OFF_ILIMBYP1     8'hDF
`define FDCL_OFF_ILIMBYP2     8'hE0
`define FDCL_OFF_DEBUG1       8'hE3
`define FDCL_OFF_FAULT        8'hF0
`define FDCL_OFF_PAGE         8'hFF
`define FDCL_PAGE_MIRROR      3'h1
`define FDCL_PAGE_BASE        3'h0
`define FDCL_TRIAL_ADDR       7'h08
`define FDCL_BIT_TRIM         0
`define FDCL_BIT_FUSE         1
`define FDCL_BIT_STEST        2
`define FDCL_NREG             9
`endif

//--- inc/fdcl_pkg.sv
// Types for the fuse config loader
// Assumes fdcl_consts.svh defines register count
`include "fdcl_consts.svh"
package fdcl_pkg;
    typedef enum logic [2:0] {
        FDCL_IDLE,
        FDCL_FUSE_LOAD,
        FDCL_MIRROR_XFER,
        FDCL_QUICK_OFF,
        FDCL_POWERED,
        FDCL_BURN
    } fdcl_state_t;
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fdcl_regreq_t;
    typedef struct packed {
        logic trimFail;
        logic fuseFail;
        logic stestFail;
    } fdcl_faults_t;
endpackage

//--- design/fuse_default_config_loader.sv
// Fuse default configuration loader: fuses to mirror, mirror to functional registers
// Assumes an I2C slave engine presenting decoded register accesses on this clock
`timescale 1ns/1ps
`include "fdcl_consts.svh"

// Operation
// - Fuse load only when fuse programming supply pin is at ground.
// - Copy fuses to mirror on each rising crossing of undervoltage detect.
// - Second stage copies mirror into functional registers.
// - Mirror keeps defaults and feeds every later power-up.
// - Mirror writable only in trial configuration mode.
// - Load or self-test failure sets flag; power-up ignored until cleared.
// - Fault flags writable only with trial pin high.
// - Trial mode ignores low-power-off select, always enters quick power-up off.
// - Trial mode still reports self-test result in its flag.
// - Trial mode uses plain framing: no CRC, no secure write.
// - Trial mode answers at I2C address 0x08.
// - Trial mode disables external and internal watchdog.
// - Page select of three bits; mirror sits in extended page 1.
// - Trial pin low refuses all extended page access.
// - Power-up with trial pin high keeps trial restrictions.
// - Supply falling below detect level resets mirror.
// - Fuse burning only in trial mode and quick power-up off.
module fuse_default_config_loader #(
    parameter int NREG = `FDCL_NREG
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   trialConfigEnablePin,
    input  wire logic                   fuseProgramSupplyPin,
    input  wire logic                   inputSupplyAboveDetect,
    input  wire logic [NREG*8-1:0]      fuseBank,
    input  wire logic                   trimLoadFail,
    input  wire logic                   fuseLoadFail,
    input  wire logic                   selfTestDone,
    input  wire logic                   selfTestFail,
    input  wire logic                   lowPowerOffSelect,
    input  wire logic                   powerUpEvent,
    input  wire logic                   burnRequest,
    input  wire logic [6:0]             fuseI2cAddr,
    input  wire fdcl_pkg::fdcl_regreq_t regReq,
    output logic      [7:0]             regRdata,
    output logic                        regAck,
    output logic      [NREG*8-1:0]      functionalCfg,
    output logic                        trialConfigMode,
    output logic                        quickPowerupOffState,
    output logic                        powerUpGo,
    output logic                        burnStrobe,
    output logic      [6:0]             i2cAddr,
    output logic                        crcEnable,
    output logic                        secureWriteEnable,
    output logic                        watchdogEnable,
    output fdcl_pkg::fdcl_faults_t      faults
);
    import fdcl_pkg::*;

    // ************************************************
    // Input synchronisers
    // ************************************************
    logic [2:0] trialSync_r;
    logic [2:0] vddSync_r;
    logic [2:0] supSync_r;
    logic       trialPin_r;
    logic       vddLow_r;
    logic       supOk_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trialSync_r <= 3'h0;
            vddSync_r   <= 3'h0;
            supSync_r   <= 3'h0;
        end else begin
            trialSync_r <= {trialSync_r[1:0], trialConfigEnablePin};
            vddSync_r   <= {vddSync_r[1:0], fuseProgramSupplyPin};
            supSync_r   <= {supSync_r[1:0], inputSupplyAboveDetect};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trialPin_r <= 1'b0;
            vddLow_r   <= 1'b0;
            supOk_r    <= 1'b0;
        end else begin
            if (trialSync_r[2] == trialSync_r[1]) trialPin_r <= trialSync_r[2];
            if (vddSync_r[2] == vddSync_r[1]) vddLow_r <= !vddSync_r[2];
            if (supSync_r[2] == supSync_r[1]) supOk_r <= supSync_r[2];
        end
    end

    // ************************************************
    // Supply edge detect
    // ************************************************
    // Reset value matches the low idle level, so no false rise after reset
    logic supOkDly_r;
    always_ff @(posedge clk) begin
        if (!rst_n) supOkDly_r <= 1'b0;
        else supOkDly_r <= supOk_r;
    end
    wire supRise = supOk_r && !supOkDly_r;
    wire supFall = !supOk_r && supOkDly_r;

    // ************************************************
    // State machine
    // ************************************************
    fdcl_state_t state_r;
    fdcl_state_t state_nxt;
    logic        faultAny;
    assign faultAny = faults.trimFail || faults.fuseFail || faults.stestFail;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FDCL_IDLE: begin
                if (supRise && vddLow_r) state_nxt = FDCL_FUSE_LOAD;
            end
            FDCL_FUSE_LOAD: begin
                state_nxt = FDCL_MIRROR_XFER;
            end
            FDCL_MIRROR_XFER: begin
                if (selfTestDone) begin
                    // Trial mode always lands in quick power-up off
                    if (trialPin_r || lowPowerOffSelect) state_nxt = FDCL_QUICK_OFF;
                    else state_nxt = FDCL_IDLE;
                end
            end
            FDCL_QUICK_OFF: begin
                if (burnRequest && trialPin_r) state_nxt = FDCL_BURN;
                else if (powerUpEvent && !faultAny) state_nxt = FDCL_POWERED;
            end
            FDCL_POWERED: begin
                state_nxt = FDCL_POWERED;
            end
            FDCL_BURN: begin
                state_nxt = FDCL_QUICK_OFF;
            end
            default: begin
                state_nxt = FDCL_IDLE;
            end
        endcase
        if (supFall) state_nxt = FDCL_IDLE;
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) state_r <= FDCL_IDLE;
        else state_r <= state_nxt;
    end

    // ************************************************
    // Mirror and functional registers
    // ************************************************
    logic [7:0] mirror_r [NREG];
    logic [7:0] func_r   [NREG];
    logic [2:0] page_r;
    logic [7:0] offTab [NREG];
    assign offTab[0] = `FDCL_OFF_LDO3_CFG;
    assign offTab[1] = `FDCL_OFF_VSNVS_CFG;
    assign offTab[2] = `FDCL_OFF_OVBYP1;
    assign offTab[3] = `FDCL_OFF_OVBYP2;
    assign offTab[4] = `FDCL_OFF_UVBYP1;
    assign offTab[5] = `FDCL_OFF_UVBYP2;
    assign offTab[6] = `FDCL_OFF_ILIMBYP1;
    assign offTab[7] = `FDCL_OFF_ILIMBYP2;
    assign offTab[8] = `FDCL_OFF_DEBUG1;

    wire extAllowed = trialPin_r && (page_r == `FDCL_PAGE_MIRROR);

    always_ff @(posedge clk) begin
        if (!rst_n || supFall) begin
            for (int i = 0; i < NREG; i++) mirror_r[i] <= 8'h00;
        end else if (state_r == FDCL_FUSE_LOAD) begin
            for (int i = 0; i < NREG; i++) mirror_r[i] <= fuseBank[i*8 +: 8];
        end else if (regReq.wrEn && extAllowed) begin
            for (int i = 0; i < NREG; i++)
                if (regReq.addr == offTab[i]) mirror_r[i] <= regReq.wdata;
        end
    end

    // Mirror feeds functional set at load and on each power-up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NREG; i++) func_r[i] <= 8'h00;
        end else if (state_r == FDCL_MIRROR_XFER
                     || (state_r == FDCL_QUICK_OFF && state_nxt == FDCL_POWERED)) begin
            for (int i = 0; i < NREG; i++) func_r[i] <= mirror_r[i];
        end else if (regReq.wrEn && !extAllowed && state_r == FDCL_POWERED) begin
            for (int i = 0; i < NREG; i++)
                if (regReq.addr == offTab[i]) func_r[i] <= regReq.wdata;
        end
    end

    // ************************************************
    // Page select
    // ************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) page_r <= `FDCL_PAGE_BASE;
        else if (regReq.wrEn && regReq.addr == `FDCL_OFF_PAGE) page_r <= regReq.wdata[2:0];
    end

    // ************************************************
    // Fault flags
    // ************************************************
    wire flagClr = regReq.wrEn && regReq.addr == `FDCL_OFF_FAULT && trialPin_r
                   && state_r == FDCL_QUICK_OFF;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            faults <= '0;
        end else begin
            // Set wins over clear
            if (trimLoadFail) faults.trimFail <= 1'b1;
            else if (flagClr && regReq.wdata[`FDCL_BIT_TRIM]) faults.trimFail <= 1'b0;
            if (fuseLoadFail) faults.fuseFail <= 1'b1;
            else if (flagClr && regReq.wdata[`FDCL_BIT_FUSE]) faults.fuseFail <= 1'b0;
            if (selfTestDone && state_r == FDCL_MIRROR_XFER) faults.stestFail <= selfTestFail;
            else if (selfTestFail) faults.stestFail <= 1'b1;
            else if (flagClr && regReq.wdata[`FDCL_BIT_STEST]) faults.stestFail <= 1'b0;
        end
    end

    // ************************************************
    // Read path
    // ************************************************
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = 8'h00;
        if (regReq.addr == `FDCL_OFF_PAGE) rd_nxt = {5'h00, page_r};
        else if (regReq.addr == `FDCL_OFF_FAULT)
            rd_nxt = {5'h00, faults.stestFail, faults.fuseFail, faults.trimFail};
        for (int i = 0; i < NREG; i++)
            if (regReq.addr == offTab[i]) rd_nxt = extAllowed ? mirror_r[i] : func_r[i];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
            regAck   <= 1'b0;
        end else begin
            regRdata <= regReq.rdEn ? rd_nxt : regRdata;
            regAck   <= regReq.rdEn || regReq.wrEn;
        end
    end

    // ************************************************
    // Functional configuration outputs
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : gFunc
            assign functionalCfg[g*8 +: 8] = func_r[g];
        end
    endgenerate

    // ************************************************
    // Trial state latched at power-up
    // ************************************************
    localparam logic [6:0] fuseI2cAddr_r0 = 7'h00;
    logic trialAtPwr_r;
    always_ff @(posedge clk) begin
        if (!rst_n) trialAtPwr_r <= 1'b0;
        else if (state_r == FDCL_QUICK_OFF && state_nxt == FDCL_POWERED) trialAtPwr_r <= trialPin_r;
        else if (state_r == FDCL_IDLE) trialAtPwr_r <= 1'b0;
    end

    // ************************************************
    // Registered outputs, plus the combinational quick power-up off flag
    // ************************************************
    logic restrict_nxt;
    assign restrict_nxt = trialPin_r || trialAtPwr_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trialConfigMode   <= 1'b0;
            i2cAddr           <= fuseI2cAddr_r0;
            crcEnable         <= 1'b0;
            secureWriteEnable <= 1'b0;
            watchdogEnable    <= 1'b0;
            burnStrobe        <= 1'b0;
            powerUpGo         <= 1'b0;
        end else begin
            trialConfigMode   <= restrict_nxt;
            i2cAddr           <= restrict_nxt ? `FDCL_TRIAL_ADDR : fuseI2cAddr;
            crcEnable         <= !restrict_nxt;
            secureWriteEnable <= !restrict_nxt;
            watchdogEnable    <= !restrict_nxt && state_r == FDCL_POWERED;
            burnStrobe        <= state_r == FDCL_BURN;
            powerUpGo         <= state_r == FDCL_QUICK_OFF && state_nxt == FDCL_POWERED;
        end
    end

    assign quickPowerupOffState = (state_r == FDCL_QUICK_OFF);
endmodule

//--- tb/fdcl_host_model.sv
// Host model: register master on the decoded access port
// Assumes strobes are taken on the rising edge, answer one cycle later
`timescale 1ns/1ps
module fdcl_host_model (
    input  wire logic         clk,
    input  wire logic [7:0]   regRdata,
    output fdcl_pkg::fdcl_regreq_t regReq
);
    import fdcl_pkg::*;
    initial regReq = '0;
    // One-cycle strobe, read data taken one and a half cycles after the taking edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        regReq = '{w, !w, a, d};
        @(negedge clk);
        regReq = '0;
        @(negedge clk);
        q = regRdata;
    endtask
endmodule

//--- tb/fdcl_asserts.sv
// Port checker for the fuse config loader
// Assumes it is bound into the loader module
`timescale 1ns/1ps
module fdcl_asserts (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire fdcl_pkg::fdcl_regreq_t regReq,
    input wire logic              regAck,
    input wire logic              selfTestDone,
    input wire logic              selfTestFail,
    input wire logic              trialConfigMode,
    input wire logic              quickPowerupOffState,
    input wire logic              powerUpGo,
    input wire logic              burnStrobe,
    input wire logic [6:0]        i2cAddr,
    input wire logic              crcEnable,
    input wire logic              secureWriteEnable,
    input wire logic              watchdogEnable,
    input wire fdcl_pkg::fdcl_faults_t faults
);
    import fdcl_pkg::*;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_ADDR: assert property (trialConfigMode |-> i2cAddr == 7'h08)
        else $error("trial address wrong");
    AST_PLAIN: assert property (trialConfigMode |-> !crcEnable && !secureWriteEnable)
        else $error("crc or secure write on in trial");
    AST_WDOG: assert property (trialConfigMode |-> !watchdogEnable)
        else $error("watchdog on in trial");
    AST_BURN: assert property (burnStrobe |-> $past(trialConfigMode, 2) && $past(quickPowerupOffState, 2))
        else $error("burn outside trial off state");
    AST_POWER_UP_EVENT: assert property (powerUpGo |-> $past(faults) == 3'h0)
        else $error("power-up with fault set");
    AST_CLR: assert property ($fell(faults.trimFail) || $fell(faults.fuseFail) |->
        $past(trialConfigMode) && $past(quickPowerupOffState))
        else $error("fault cleared while locked");
    AST_QPU: assert property (selfTestDone && trialConfigMode |-> ##[1:3] quickPowerupOffState)
        else $error("trial load missed off state");
    AST_STEST: assert property (selfTestDone && trialConfigMode |=> faults.stestFail == $past(selfTestFail))
        else $error("self-test flag wrong");
    AST_ACK: assert property (regReq.wrEn || regReq.rdEn |=> regAck)
        else $error("register access not acknowledged");
endmodule
bind fuse_default_config_loader fdcl_asserts fdcl_asserts_i (.clk, .rst_n, .regReq, .regAck, .selfTestDone, .selfTestFail,
    .trialConfigMode, .quickPowerupOffState, .powerUpGo, .burnStrobe, .i2cAddr, .crcEnable,
    .secureWriteEnable, .watchdogEnable, .faults);

//--- tb/fuse_default_config_loader_tb.sv
// Testbench for the fuse config loader
// Assumes fdcl_pkg compiled first; checker binds itself
`timescale 1ns/1ps
module fuse_default_config_loader_tb;
    import fdcl_pkg::*;
    localparam logic [71:0] FUSE = 72'h998877665544332211;
    logic clk = 0, rst_n = 0, trialConfigEnablePin = 0, fuseProgramSupplyPin = 0, inputSupplyAboveDetect = 0;
    logic trimLoadFail = 0, fuseLoadFail = 0, selfTestDone = 0, selfTestFail = 0, lowPowerOffSelect = 0;
    logic powerUpEvent = 0, burnRequest = 0, regAck, trialConfigMode, quickPowerupOffState, powerUpGo;
    logic burnStrobe, crcEnable, secureWriteEnable, watchdogEnable, sawGo = 0, sawBurn = 0;
    logic [71:0] fuseBank = FUSE, functionalCfg;
    logic [6:0] fuseI2cAddr = 7'h2A, i2cAddr;
    logic [7:0] regRdata, rdv;
    fdcl_regreq_t regReq;
    fdcl_faults_t faults;
    int numErrors = 0, nCompared = 0;
    always #20 clk = ~clk;
    always @(negedge clk) begin
        sawGo |= powerUpGo;
        sawBurn |= burnStrobe;
    end
    fuse_default_config_loader #(.NREG(9)) fuse_default_config_loader_i (.clk, .rst_n, .trialConfigEnablePin,
        .fuseProgramSupplyPin, .inputSupplyAboveDetect, .fuseBank, .trimLoadFail, .fuseLoadFail, .selfTestDone,
        .selfTestFail, .lowPowerOffSelect, .powerUpEvent, .burnRequest, .fuseI2cAddr, .regReq, .regRdata, .regAck,
        .functionalCfg, .trialConfigMode, .quickPowerupOffState, .powerUpGo, .burnStrobe, .i2cAddr, .crcEnable,
        .secureWriteEnable, .watchdogEnable, .faults);
    fdcl_host_model fdcl_host_model_i (.clk, .regRdata, .regReq);
    task automatic chk(string nm, logic [71:0] seen, logic [71:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        fdcl_host_model_i.xfer(1'b1, a, d, rdv);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
        fdcl_host_model_i.xfer(1'b0, a, 8'h00, rdv);
        chk(nm, 72'(rdv), 72'(exp));
    endtask
    // Supply dip and rise, then self-test result
    task automatic load(logic fail);
        inputSupplyAboveDetect = 0;
        cyc(4);
        inputSupplyAboveDetect = 1;
        cyc(10);
        selfTestFail = fail;
        selfTestDone = 1;
        cyc(1);
        selfTestDone = 0;
        selfTestFail = 0;
        cyc(3);
    endtask
    task automatic t_load;
        lowPowerOffSelect = 1;
        load(1'b0);
        chk("cfg", functionalCfg, FUSE);
        chk("qpu", 72'(quickPowerupOffState), 72'h1);
        $display("test load done");
    endtask
    task automatic t_lock;
        trimLoadFail = 1;
        cyc(1);
        trimLoadFail = 0;
        wr(8'hF0, 8'h01);
        chk("trim", 72'(faults), 72'h4);
        powerUpEvent = 1;
        cyc(6);
        powerUpEvent = 0;
        chk("go", 72'(sawGo), 72'h0);
        $display("test lock done");
    endtask
    task automatic t_refuse;
        wr(8'hFF, 8'h01);
        wr(8'hD6, 8'hAA);
        trialConfigEnablePin = 1;
        cyc(6);
        wr(8'hFF, 8'h01);
        rd(8'hD6, 8'h11, "kept");
        chk("addr", 72'(i2cAddr), 72'h08);
        chk("plain", 72'({crcEnable, secureWriteEnable, watchdogEnable}), 72'h0);
        $display("test refuse done");
    endtask
    task automatic t_trial;
        wr(8'hD6, 8'hA5);
        rd(8'hD6, 8'hA5, "mirror");
        rd(8'hDA, 8'h22, "mirror2");
        lowPowerOffSelect = 0;
        load(1'b1);
        chk("qpu", 72'(quickPowerupOffState), 72'h1);
        chk("stest", 72'(faults.stestFail), 72'h1);
        wr(8'hFF, 8'h01);
        rd(8'hD6, 8'h11, "reload");
        wr(8'hF0, 8'h07);
        chk("clr", 72'(faults), 72'h0);
        burnRequest = 1;
        cyc(1);
        burnRequest = 0;
        cyc(3);
        chk("burn", 72'(sawBurn), 72'h1);
        powerUpEvent = 1;
        cyc(6);
        powerUpEvent = 0;
        trialConfigEnablePin = 0;
        cyc(6);
        chk("go", 72'(sawGo), 72'h1);
        chk("addr", 72'(i2cAddr), 72'h08);
        $display("test trial done");
    endtask
    task automatic testDone;
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        numErrors++;
        testDone;
    end
    initial begin
        cyc(4);
        rst_n = 1;
        cyc(4);
        chk("rst", 72'({faults, powerUpGo, trialConfigMode}), 72'h0);
        t_load;
        t_lock;
        t_refuse;
        t_trial;
        testDone;
    end
endmodule
